/* File: test/aie_add_exec_test.sv */
`timescale 1ns/100ps
`default_nettype none
module aie_add_exec_test;
  import aie_pkg::*;
  // ***********************************************
  // clock, reset and apb signals
  // ***********************************************
  logic pclk = 1'b0; // 20 MHz core clock
  logic presetn = 1'b0; // held low at time zero
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_mismatch = 0; // mismatches seen
  int tests_run = 0; // comparisons made

  // half period of 25 ns gives the 50 ns cycle
  always #25 pclk = ~pclk;

  aie_add_exec #(.ADDR_W(12)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // ***********************************************
  // verdict and comparison
  // ***********************************************
  task automatic results();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // ***********************************************
  // apb master: setup, then access held until pready
  // ***********************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // values read here are those sampled at the edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: no pready", $time);
      results();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // read a word and compare data and error response
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rchk

  // start one instruction and poll busy under a bound
  task automatic exec(input logic [15:0] ins);
    logic [31:0] r;
    logic e;
    int n;
    wr(AIE_OFF_INSTR, {16'h0000, ins});
    n = 0;
    do
    begin
      apb(1'b0, AIE_OFF_STATUS, 32'h0000_0000, r, e);
      n++;
    end
    while (r[AIE_STAT_BUSY] !== 1'b0 && n < 20);
    if (r[AIE_STAT_BUSY] !== 1'b0)
    begin
      n_mismatch++;
      $display("unexpected at %0t: busy never cleared", $time);
      results();
    end
  endtask : exec

  // eight-bit sum and flags {n, ov, z, dc, c}, worked out independently
  function automatic logic [7:0] fexp(input logic [7:0] a, input logic [7:0] b,
                                      output logic [4:0] f);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    f[0] = s[8];
    f[1] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    f[2] = (s[7:0] == 8'h00);
    f[3] = (a[7] == b[7]) && (s[7] != a[7]);
    f[4] = s[7];
    return s[7:0];
  endfunction : fexp

  // ***********************************************
  // scenarios
  // ***********************************************
  // reset values and an unmapped offset
  task automatic t_reset();
    rchk(AIE_OFF_ACCUM, 32'h0000_0000);
    rchk(AIE_OFF_FLAGS, 32'h0000_0000);
    rchk(AIE_OFF_STATUS, 32'h0000_0000);
    rchk(AIE_OFF_LASTADDR, 32'h0000_0000);
    rchk(8'h28, 32'h0000_0000, 1'b1);
  endtask : t_reset

  // literal add over carry, half carry, overflow and zero corners
  task automatic t_lit();
    logic [7:0] la [6] = '{8'h10, 8'h01, 8'h7F, 8'h80, 8'h08, 8'h00};
    logic [7:0] lk [6] = '{8'h15, 8'hFF, 8'h01, 8'h80, 8'h08, 8'h00};
    logic [7:0] s;
    logic [4:0] f;
    for (int i = 0; i < 6; i++)
    begin
      s = fexp(la[i], lk[i], f);
      wr(AIE_OFF_ACCUM, {24'h0, la[i]});
      exec({AIE_LIT_OPC, lk[i]});
      rchk(AIE_OFF_ACCUM, {24'h0, s});
      rchk(AIE_OFF_FLAGS, {27'h0, f});
    end
  endtask : t_lit

  // file add over every destination, bank and extended-set case
  task automatic t_file();
    logic [15:0] ins [8] = '{16'h25C2, 16'h2710, 16'h2420, 16'h2680,
                             16'h245F, 16'h2660, 16'h2705, 16'h2400};
    logic [3:0] bk [8] = '{4'h3, 4'hA, 4'h5, 4'h5, 4'h5, 4'h5, 4'h2, 4'h5};
    logic [11:0] ad [8] = '{12'h3C2, 12'hA10, 12'h020, 12'hF80,
                            12'h04F, 12'hF60, 12'h205, 12'hFF0};
    logic [7:0] ex = 8'hF0; // extended set on for the last four
    logic [7:0] w;
    logic [7:0] m;
    logic [7:0] s;
    logic [4:0] f;
    for (int i = 0; i < 8; i++)
    begin
      w = 8'h17 + 8'(i * 37);
      m = 8'hC2 - 8'(i * 29);
      s = fexp(w, m, f);
      wr(AIE_OFF_CTRL, {31'h0, ex[i]});
      wr(AIE_OFF_BANK, {28'h0, bk[i]});
      // base near the top so the indexed sum wraps
      wr(AIE_OFF_IDXBASE, 32'h0000_0FF0);
      wr(AIE_OFF_MEMADDR, {20'h0, ad[i]});
      wr(AIE_OFF_MEMDATA, {24'h0, m});
      wr(AIE_OFF_ACCUM, {24'h0, w});
      exec(ins[i]);
      rchk(AIE_OFF_LASTADDR, {20'h0, ad[i]});
      rchk(AIE_OFF_ACCUM, {24'h0, ins[i][AIE_INS_DEST] ? w : s});
      rchk(AIE_OFF_MEMDATA, {24'h0, ins[i][AIE_INS_DEST] ? s : m});
      rchk(AIE_OFF_FLAGS, {27'h0, f});
    end
  endtask : t_file

  // busy spans the four phases, result lands after them
  task automatic t_phase();
    wr(AIE_OFF_ACCUM, 32'h0000_0010);
    wr(AIE_OFF_INSTR, 32'h0000_0F15);
    rchk(AIE_OFF_STATUS, 32'h0000_0001);
    exec(16'h0000);
    rchk(AIE_OFF_ACCUM, 32'h0000_0025);
  endtask : t_phase

  // carry-in add pattern is not an add here: no write, sticky flag
  task automatic t_illegal();
    wr(AIE_OFF_STATUS, 32'h0000_0002);
    wr(AIE_OFF_ACCUM, 32'h0000_0055);
    exec(16'h2142);
    rchk(AIE_OFF_STATUS, 32'h0000_0002);
    rchk(AIE_OFF_ACCUM, 32'h0000_0055);
    wr(AIE_OFF_STATUS, 32'h0000_0002);
    rchk(AIE_OFF_STATUS, 32'h0000_0000);
  endtask : t_illegal

  // ***********************************************
  // main sequence
  // ***********************************************
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lit();
    t_file();
    t_phase();
    t_illegal();
    results();
  end
endmodule : aie_add_exec_test
`default_nettype wire

/* File: verilog/aie_add_exec.sv */
// Behaviour
// (RULE_01) literal add sums immediate into accumulator
// (RULE_02) file add sums accumulator and memory byte
// (RULE_03) destination 0 writes accumulator, memory kept
// (RULE_04) destination 1 writes sum back to byte
// (RULE_05) bank bit 0 uses fixed access bank
// (RULE_06) bank bit 1 joins bank register, address
// (RULE_07) extended set, low address: indexed offset
// (RULE_08) four phases: decode, read, compute, write
// (RULE_09) flags follow usual eight-bit add meaning
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module aie_add_exec
  import aie_pkg::*;
#(
  parameter int ADDR_W = 12 // data memory address width, bank plus byte
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import aie_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [7:0] mem [0:(1<<ADDR_W)-1]; // data memory
  logic ext_en_q; // extended instruction set enabled
  logic [15:0] instr_q; // instruction word under execution
  logic [7:0] accum_q; // working register
  logic [3:0] bank_q; // bank select register
  aie_flags_t flags_q; // arithmetic flags
  logic ill_q; // sticky: a non-add word was issued
  logic [11:0] idx_base_q; // base of indexed literal offset mode
  logic [11:0] mem_ptr_q; // software memory pointer
  logic [11:0] last_addr_q; // last resolved operand address
  aie_phase_t phase_q; // current quarter phase
  aie_dec_t dec_q; // decoded instruction
  logic [7:0] opnd_w_q; // accumulator operand
  logic [7:0] opnd_f_q; // literal or memory operand
  aie_res_t res_q; // sum and flags
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic bus_wr; // write takes effect this edge
  logic bus_rd_setup; // read data is captured this edge
  logic exec_mem_we; // execution writes memory this edge
  logic exec_acc_we; // execution writes accumulator this edge

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ***************************************************************
  // helper functions
  // ***************************************************************
  // true for an offset that holds a register
  function automatic logic aie_map_ok(input logic [7:0] a);
    return a inside {AIE_OFF_CTRL, AIE_OFF_INSTR, AIE_OFF_ACCUM, AIE_OFF_BANK,
                     AIE_OFF_FLAGS, AIE_OFF_STATUS, AIE_OFF_IDXBASE, AIE_OFF_MEMADDR,
                     AIE_OFF_MEMDATA, AIE_OFF_LASTADDR};
  endfunction : aie_map_ok

  // data memory address of a file operand
  function automatic logic [11:0] aie_resolve(input logic [15:0] ins,
                                              input logic [3:0] bank,
                                              input logic ext,
                                              input logic [11:0] base);
    if (ins[AIE_INS_BANK])
    begin
      return {bank, ins[7:0]}; // RULE_06
    end
    else if (ext && ins[7:0] < AIE_ACC_SPLIT)
    begin
      return 12'(base + {4'h0, ins[7:0]}); // RULE_07
    end
    else if (ins[7:0] < AIE_ACC_SPLIT)
    begin
      return {4'h0, ins[7:0]}; // RULE_05
    end
    else
    begin
      return {AIE_ACC_HIGH_BANK, ins[7:0]}; // RULE_05
    end
  endfunction : aie_resolve

  // ***************************************************************
  // apb slave
  // ***************************************************************
  // one wait state: data are captured in the first access cycle, so a
  // memory read never needs a combinational path to prdata
  assign bus_wr = psel && penable && pwrite && pready_q;
  assign bus_rd_setup = psel && penable && !pready_q;

  // handshake and error answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !aie_map_ok(paddr);
    end
  end

  // read data capture; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (bus_rd_setup)
    begin
      unique case (paddr)
        AIE_OFF_CTRL: prdata_q <= {31'h0, ext_en_q};
        AIE_OFF_INSTR: prdata_q <= {16'h0, instr_q};
        AIE_OFF_ACCUM: prdata_q <= {24'h0, accum_q};
        AIE_OFF_BANK: prdata_q <= {28'h0, bank_q};
        AIE_OFF_FLAGS: prdata_q <= {27'h0, flags_q};
        AIE_OFF_STATUS: prdata_q <= {30'h0, ill_q, phase_q != AIE_PH_IDLE};
        AIE_OFF_IDXBASE: prdata_q <= {20'h0, idx_base_q};
        AIE_OFF_MEMADDR: prdata_q <= {20'h0, mem_ptr_q};
        AIE_OFF_MEMDATA: prdata_q <= {24'h0, mem[mem_ptr_q]};
        AIE_OFF_LASTADDR: prdata_q <= {20'h0, last_addr_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_en_q <= 1'b0;
      bank_q <= 4'h0;
      idx_base_q <= AIE_RST_ADDR;
      mem_ptr_q <= AIE_RST_ADDR;
    end
    else if (bus_wr)
    begin
      if (paddr == AIE_OFF_CTRL) ext_en_q <= pwdata[0];
      if (paddr == AIE_OFF_BANK) bank_q <= pwdata[3:0];
      if (paddr == AIE_OFF_IDXBASE) idx_base_q <= pwdata[11:0];
      if (paddr == AIE_OFF_MEMADDR) mem_ptr_q <= pwdata[11:0];
    end
  end

  // ***************************************************************
  // quarter-phase sequencer
  // ***************************************************************
  // a new word is taken only while idle; writes during execution are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= AIE_PH_IDLE;
      instr_q <= AIE_RST_INSTR;
    end
    else
    begin
      unique case (phase_q) // RULE_08
        AIE_PH_IDLE:
        begin
          if (bus_wr && paddr == AIE_OFF_INSTR)
          begin
            instr_q <= pwdata[15:0];
            phase_q <= AIE_PH_Q1;
          end
        end
        AIE_PH_Q1: phase_q <= AIE_PH_Q2;
        AIE_PH_Q2: phase_q <= AIE_PH_Q3;
        AIE_PH_Q3: phase_q <= AIE_PH_Q4;
        AIE_PH_Q4: phase_q <= AIE_PH_IDLE;
        default: phase_q <= AIE_PH_IDLE;
      endcase
    end
  end

  // q1: decode; bank and base are sampled here, later changes do not matter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_q <= '0;
      last_addr_q <= AIE_RST_ADDR;
    end
    else if (phase_q == AIE_PH_Q1)
    begin
      dec_q.lit <= instr_q[7:0];
      dec_q.to_file <= instr_q[AIE_INS_DEST];
      dec_q.addr <= aie_resolve(instr_q, bank_q, ext_en_q, idx_base_q);
      if (instr_q[15:8] == AIE_LIT_OPC)
      begin
        dec_q.op <= AIE_OP_LIT; // RULE_01
      end
      else if (instr_q[15:10] == AIE_FILE_OPC)
      begin
        dec_q.op <= AIE_OP_FILE; // RULE_02
        last_addr_q <= aie_resolve(instr_q, bank_q, ext_en_q, idx_base_q);
      end
      else
      begin
        dec_q.op <= AIE_OP_NONE;
      end
    end
  end

  // q2: read operands; the literal needs no memory access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opnd_w_q <= AIE_RST_BYTE;
      opnd_f_q <= AIE_RST_BYTE;
    end
    else if (phase_q == AIE_PH_Q2)
    begin
      opnd_w_q <= accum_q;
      opnd_f_q <= (dec_q.op == AIE_OP_FILE) ? mem[dec_q.addr] : dec_q.lit;
    end
  end

  // q3: sum and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_q <= '0;
    end
    else if (phase_q == AIE_PH_Q3)
    begin
      {res_q.flags.carry, res_q.sum} <= {1'b0, opnd_w_q} + {1'b0, opnd_f_q}; // RULE_09
      res_q.flags.nibble_carry_flag <= 5'({1'b0, opnd_w_q[3:0]} + {1'b0, opnd_f_q[3:0]}) > 5'h0F;
      res_q.flags.zero <= 8'(opnd_w_q + opnd_f_q) == 8'h00;
      res_q.flags.neg <= 8'(opnd_w_q + opnd_f_q) >> 7 == 8'h01;
      // overflow only when like signs give a sum of the other sign
      res_q.flags.signed_wrap_flag <= (opnd_w_q[7] == opnd_f_q[7])
                                      && (8'(opnd_w_q + opnd_f_q) >> 7 != {7'h0, opnd_w_q[7]});
    end
  end

  // ***************************************************************
  // q4: write destination
  // ***************************************************************
  assign exec_mem_we = (phase_q == AIE_PH_Q4) && (dec_q.op == AIE_OP_FILE) && dec_q.to_file;
  assign exec_acc_we = (phase_q == AIE_PH_Q4) && ((dec_q.op == AIE_OP_LIT)
                       || (dec_q.op == AIE_OP_FILE && !dec_q.to_file));

  // execution wins over a software write in the same edge
  always_ff @(posedge pclk)
  begin
    if (exec_mem_we)
    begin
      mem[dec_q.addr] <= res_q.sum; // RULE_04
    end
    else if (bus_wr && paddr == AIE_OFF_MEMDATA)
    begin
      mem[mem_ptr_q] <= pwdata[7:0];
    end
  end

  // working register: the sum goes here for literal adds and destination 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accum_q <= AIE_RST_BYTE;
    end
    else if (exec_acc_we)
    begin
      accum_q <= res_q.sum; // RULE_03
    end
    else if (bus_wr && paddr == AIE_OFF_ACCUM)
    begin
      accum_q <= pwdata[7:0];
    end
  end

  // flags: hardware update wins over software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= '0;
    end
    else if (phase_q == AIE_PH_Q4 && dec_q.op != AIE_OP_NONE)
    begin
      flags_q <= res_q.flags; // RULE_09
    end
    else if (bus_wr && paddr == AIE_OFF_FLAGS)
    begin
      flags_q <= pwdata[4:0];
    end
  end

  // illegal word flag: set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ill_q <= 1'b0;
    end
    else if (phase_q == AIE_PH_Q2 && dec_q.op == AIE_OP_NONE)
    begin
      ill_q <= 1'b1;
    end
    else if (bus_wr && paddr == AIE_OFF_STATUS && pwdata[AIE_STAT_ILL])
    begin
      ill_q <= 1'b0;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_lit_add;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q1 && instr_q[15:8] == AIE_LIT_OPC)
      |-> ##4 accum_q == 8'($past(accum_q, 4) + $past(instr_q[7:0], 4));
  endproperty
  a_lit_add: assert property (p_lit_add) else $error("literal add result wrong"); // RULE_01

  property p_file_sum;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q4 && dec_q.op == AIE_OP_FILE)
      |-> {res_q.flags.carry, res_q.sum} == {1'b0, opnd_w_q} + {1'b0, opnd_f_q};
  endproperty
  a_file_sum: assert property (p_file_sum) else $error("file add sum wrong"); // RULE_02

  property p_dest_w;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q4 && dec_q.op == AIE_OP_FILE && !dec_q.to_file)
      |-> !exec_mem_we ##1 accum_q == $past(res_q.sum);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("destination 0 misrouted"); // RULE_03

  property p_dest_f;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q4 && dec_q.op == AIE_OP_FILE && dec_q.to_file)
      |=> mem[$past(dec_q.addr)] == $past(res_q.sum) && $stable(accum_q);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("destination 1 misrouted"); // RULE_04

  property p_access;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q1 && !instr_q[AIE_INS_BANK] && !(ext_en_q && instr_q[7:0] < AIE_ACC_SPLIT))
      |=> dec_q.addr[11:8] == ($past(instr_q[7:0]) < AIE_ACC_SPLIT ? 4'h0 : AIE_ACC_HIGH_BANK);
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong"); // RULE_05

  property p_banked;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q1 && instr_q[AIE_INS_BANK])
      |=> dec_q.addr == {$past(bank_q), $past(instr_q[7:0])};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong"); // RULE_06

  property p_indexed;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q1 && !instr_q[AIE_INS_BANK] && ext_en_q && instr_q[7:0] <= 8'h5F)
      |=> dec_q.addr == 12'($past(idx_base_q) + {4'h0, $past(instr_q[7:0])});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // RULE_07

  property p_phases;
    @(posedge pclk) disable iff (!presetn)
    phase_q == AIE_PH_Q1 |=> phase_q == AIE_PH_Q2 ##1 phase_q == AIE_PH_Q3
      ##1 phase_q == AIE_PH_Q4 ##1 phase_q == AIE_PH_IDLE;
  endproperty
  a_phases: assert property (p_phases) else $error("quarter phase order broken"); // RULE_08

  property p_flags;
    @(posedge pclk) disable iff (!presetn)
    (phase_q == AIE_PH_Q4 && dec_q.op != AIE_OP_NONE)
      |=> flags_q.zero == (8'($past(opnd_w_q) + $past(opnd_f_q)) == 8'h00)
          && flags_q.carry == (({1'b0, $past(opnd_w_q)} + {1'b0, $past(opnd_f_q)}) > 9'h0FF)
          && flags_q.nibble_carry_flag == (({1'b0, $past(opnd_w_q[3:0])}
                                             + {1'b0, $past(opnd_f_q[3:0])}) > 5'h0F)
          && flags_q.neg == $past(res_q.sum[7])
          && flags_q.signed_wrap_flag == ($past(opnd_w_q[7]) == $past(opnd_f_q[7])
                                          && $past(res_q.sum[7]) != $past(opnd_w_q[7]));
  endproperty
  a_flags: assert property (p_flags) else $error("flag update wrong"); // RULE_09
endmodule : aie_add_exec
`default_nettype wire

/* File: verilog/aie_pkg.sv */
`default_nettype none
package aie_pkg;
  // ***************************************************************
  // register byte offsets on the apb bus
  // ***************************************************************
  localparam logic [7:0] AIE_OFF_CTRL = 8'h00; // extended set enable
  localparam logic [7:0] AIE_OFF_INSTR = 8'h04; // instruction word, write starts it
  localparam logic [7:0] AIE_OFF_ACCUM = 8'h08; // working register
  localparam logic [7:0] AIE_OFF_BANK = 8'h0C; // bank select register
  localparam logic [7:0] AIE_OFF_FLAGS = 8'h10; // arithmetic flags
  localparam logic [7:0] AIE_OFF_STATUS = 8'h14; // busy and illegal
  localparam logic [7:0] AIE_OFF_IDXBASE = 8'h18; // indexed offset base
  localparam logic [7:0] AIE_OFF_MEMADDR = 8'h1C; // software memory pointer
  localparam logic [7:0] AIE_OFF_MEMDATA = 8'h20; // byte at the memory pointer
  localparam logic [7:0] AIE_OFF_LASTADDR = 8'h24; // last resolved operand address

  // ***************************************************************
  // field positions, encodings and reset values
  // ***************************************************************
  localparam int AIE_STAT_BUSY = 0; // status: execution in progress
  localparam int AIE_STAT_ILL = 1; // status: non-add word seen, write 1 clears
  localparam int AIE_INS_DEST = 9; // destination bit of the file add
  localparam int AIE_INS_BANK = 8; // bank-select bit of the file add
  localparam logic [7:0] AIE_LIT_OPC = 8'h0F; // literal add, upper byte
  localparam logic [5:0] AIE_FILE_OPC = 6'b001001; // file add, upper six bits
  localparam logic [7:0] AIE_ACC_SPLIT = 8'h60; // first upper access-bank address
  localparam logic [3:0] AIE_ACC_HIGH_BANK = 4'hF; // bank for upper access half
  localparam logic [7:0] AIE_RST_BYTE = 8'h00; // reset of byte registers
  localparam logic [15:0] AIE_RST_INSTR = 16'h0000; // reset instruction word
  localparam logic [11:0] AIE_RST_ADDR = 12'h000; // reset of address registers

  // ***************************************************************
  // types
  // ***************************************************************
  // flags, bit 4 down to bit 0
  typedef struct packed {
    logic neg; // negative
    logic signed_wrap_flag; // two's-complement overflow
    logic zero; // zero result
    logic nibble_carry_flag; // carry out of bit 3
    logic carry; // carry out of bit 7
  } aie_flags_t;

  // kind of instruction being executed
  typedef enum logic [1:0] {
    AIE_OP_NONE = 2'b00,
    AIE_OP_LIT = 2'b01,
    AIE_OP_FILE = 2'b10
  } aie_op_t;

  // decoded instruction, built in the first quarter phase
  typedef struct packed {
    aie_op_t op;
    logic to_file;
    logic [11:0] addr;
    logic [7:0] lit;
  } aie_dec_t;

  // result of the process quarter phase
  typedef struct packed {
    logic [7:0] sum;
    aie_flags_t flags;
  } aie_res_t;

  // quarter phases of one instruction cycle
  typedef enum logic [2:0] {
    AIE_PH_IDLE = 3'b000,
    AIE_PH_Q1 = 3'b001,
    AIE_PH_Q2 = 3'b010,
    AIE_PH_Q3 = 3'b011,
    AIE_PH_Q4 = 3'b100
  } aie_phase_t;
endpackage : aie_pkg
`default_nettype wire
